// *** rtl/can_mode_ctrl.sv ***
// Purpose: init/retransmit control and message object handling of a CAN controller
// Assumes: the bitstream engine sits outside; it reports frames, bit samples and tx outcome
// Notes: host reaches objects through one set of interface words (selected object), never directly
`timescale 1ns/1ps
`default_nettype none
module can_mode_ctrl (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [can_mode_pkg::ADDR_W-1:0] address,
	input wire logic [can_mode_pkg::REG_W-1:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [can_mode_pkg::REG_W-1:0] read_data,
	input wire logic bus_off,
	input wire logic bit_tick,
	input wire logic bus_bit,
	input wire logic rx_valid,
	input wire can_mode_pkg::frame_t rx_frame,
	input wire logic tx_start_ack,
	input wire logic tx_done_ok,
	input wire logic tx_failed,
	input wire logic engine_tx_bit,
	output logic tx_req,
	output can_mode_pkg::frame_t tx_frame,
	output logic transfer_enable,
	output logic tx_pin
);
	can_mode_pkg::object_t objects [can_mode_pkg::OBJECTS];
	logic [can_mode_pkg::REG_W-1:0] control;
	logic [can_mode_pkg::REG_W-1:0] bit_timing;
	logic [can_mode_pkg::REG_W-1:0] prescale_ext;
	logic [1:0] schedule_mode;
	logic [can_mode_pkg::IDX_W-1:0] select;
	can_mode_pkg::link_state_t link_state;
	can_mode_pkg::link_state_t next_link_state;
	logic [3:0] idle_count;
	logic [3:0] next_idle_count;
	logic busy;
	logic [can_mode_pkg::IDX_W-1:0] busy_idx;

	// register decode
	wire init_hold = control[can_mode_pkg::CTL_INIT];
	wire cfg_open = control[can_mode_pkg::CTL_INIT] & control[can_mode_pkg::CTL_CCE];
	wire retransmit_disable = control[can_mode_pkg::CTL_DAR];
	wire wr_control = write_strobe && address == can_mode_pkg::REG_CONTROL;
	wire wr_timing = write_strobe && address == can_mode_pkg::REG_BIT_TIMING && cfg_open;
	wire wr_prescale = write_strobe && address == can_mode_pkg::REG_PRESCALE_EXT && cfg_open;
	wire wr_mode = write_strobe && address == can_mode_pkg::REG_SCHEDULE_MODE && cfg_open;
	wire wr_select = write_strobe && address == can_mode_pkg::REG_OBJ_SELECT;
	wire data_addr = address >= can_mode_pkg::REG_OBJ_DATA0 && !address[0]
		&& address < can_mode_pkg::REG_OBJ_DATA0 + can_mode_pkg::DATA_SPAN;
	wire obj_wr = write_strobe && (address == can_mode_pkg::REG_OBJ_CTRL || address == can_mode_pkg::REG_OBJ_ID_LO
		|| address == can_mode_pkg::REG_OBJ_ID_HI || address == can_mode_pkg::REG_OBJ_MASK_LO
		|| address == can_mode_pkg::REG_OBJ_MASK_HI || data_addr);
	wire running = link_state == can_mode_pkg::LINK_ACTIVE && !init_hold;

	// bus idle detection after init release
	always_comb begin
		next_link_state = link_state;
		next_idle_count = idle_count;
		case (link_state)
			can_mode_pkg::LINK_INIT: begin
				next_idle_count = can_mode_pkg::COUNT_ZERO;
				if (!init_hold)
					next_link_state = can_mode_pkg::LINK_WAIT_IDLE;
			end
			can_mode_pkg::LINK_WAIT_IDLE: begin
				if (bit_tick)
					next_idle_count = bus_bit ? idle_count + can_mode_pkg::COUNT_ONE
						: can_mode_pkg::COUNT_ZERO;
				if (bit_tick && bus_bit && idle_count == can_mode_pkg::IDLE_COUNT - can_mode_pkg::COUNT_ONE)
					next_link_state = can_mode_pkg::LINK_ACTIVE;
			end
			can_mode_pkg::LINK_ACTIVE: next_idle_count = can_mode_pkg::COUNT_ZERO;
			default: next_link_state = can_mode_pkg::LINK_INIT;
		endcase
		if (init_hold)
			next_link_state = can_mode_pkg::LINK_INIT;
	end

	// lowest pending valid transmit object wins
	function automatic logic [can_mode_pkg::IDX_W:0] pick_pending(input logic [can_mode_pkg::OBJECTS-1:0] p);
		logic [can_mode_pkg::IDX_W:0] r;
		r = {1'b0, 5'h00};
		for (int i = can_mode_pkg::OBJECTS - 1; i >= 0; i--)
			if (p[i])
				r = {1'b1, 5'(i)};
		return r;
	endfunction

	// acceptance match of a received id against one object
	function automatic logic id_match(input can_mode_pkg::object_t o, input logic [can_mode_pkg::ID_W-1:0] id);
		logic [can_mode_pkg::ID_W-1:0] m;
		m = o.use_mask ? o.mask : '1;
		return o.valid && ((o.id ^ id) & m) == '0;
	endfunction

	logic [can_mode_pkg::OBJECTS-1:0] pend_vec;
	logic [can_mode_pkg::OBJECTS-1:0] rx_hit_vec;
	genvar g;
	generate
		for (g = 0; g < can_mode_pkg::OBJECTS; g++) begin : g_vec
			assign pend_vec[g] = objects[g].valid && objects[g].pend && objects[g].dir_tx;
			assign rx_hit_vec[g] = id_match(objects[g], rx_frame.id)
				&& (rx_frame.remote ? objects[g].dir_tx : !objects[g].dir_tx);
		end
	endgenerate
	wire [can_mode_pkg::IDX_W:0] tx_pick = pick_pending(pend_vec);
	wire [can_mode_pkg::IDX_W:0] rx_pick = pick_pending(rx_hit_vec);
	wire rx_take = rx_valid && running && rx_pick[can_mode_pkg::IDX_W];
	wire [can_mode_pkg::IDX_W-1:0] rx_idx = rx_pick[can_mode_pkg::IDX_W-1:0];
	wire [can_mode_pkg::IDX_W-1:0] tx_idx = tx_pick[can_mode_pkg::IDX_W-1:0];
	can_mode_pkg::object_t sel_obj;
	assign sel_obj = objects[select];
	wire [2:0] data_word = 3'((address - can_mode_pkg::REG_OBJ_DATA0) >> 1);

	// host update of the selected object word
	function automatic can_mode_pkg::object_t host_write(input can_mode_pkg::object_t o,
		input logic [can_mode_pkg::ADDR_W-1:0] a, input logic [15:0] d, input logic [2:0] w);
		can_mode_pkg::object_t r;
		r = o;
		case (a)
			can_mode_pkg::REG_OBJ_CTRL: begin
				r.valid = d[can_mode_pkg::OC_VALID];
				r.fresh = d[can_mode_pkg::OC_FRESH];
				r.pend = d[can_mode_pkg::OC_PEND];
				r.remote_en = d[can_mode_pkg::OC_REMOTE_EN];
				r.dir_tx = d[can_mode_pkg::OC_DIR_TX];
				r.use_mask = d[can_mode_pkg::OC_USE_MASK];
				r.dlc = d[can_mode_pkg::DLC_W-1:0];
			end
			can_mode_pkg::REG_OBJ_ID_LO: r.id[15:0] = d;
			can_mode_pkg::REG_OBJ_ID_HI: r.id[can_mode_pkg::ID_W-1:16] = d[12:0];
			can_mode_pkg::REG_OBJ_MASK_LO: r.mask[15:0] = d;
			can_mode_pkg::REG_OBJ_MASK_HI: r.mask[can_mode_pkg::ID_W-1:16] = d[12:0];
			default: r.data[w[1:0]*16 +: 16] = d;
		endcase
		return r;
	endfunction

	// object store: a host write rewrites the whole selected object, dropping internal updates to it in the same cycle
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			for (int i = 0; i < can_mode_pkg::OBJECTS; i++)
				objects[i] <= '0;
		end else begin
			if (rx_take) begin
				if (rx_frame.remote) begin
					if (objects[rx_idx].remote_en)
						objects[rx_idx].pend <= 1'b1;
				end else begin
					objects[rx_idx].id <= rx_frame.id;
					objects[rx_idx].dlc <= rx_frame.dlc;
					objects[rx_idx].data <= rx_frame.data;
					objects[rx_idx].fresh <= 1'b1;
				end
			end
			if (busy && tx_start_ack && retransmit_disable)
				objects[busy_idx].pend <= 1'b0;
			if (busy && tx_done_ok) begin
				objects[busy_idx].fresh <= 1'b0;
				objects[busy_idx].pend <= 1'b0;
			end
			if (obj_wr)
				objects[select] <= host_write(objects[select], address, write_data, data_word);
		end
	end

	// control registers; reset sets init, bus-off sets init
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			control <= can_mode_pkg::CONTROL_RESET;
			bit_timing <= can_mode_pkg::BIT_TIMING_RESET;
			prescale_ext <= '0;
			schedule_mode <= '0;
			select <= '0;
		end else begin
			if (wr_control)
				control <= write_data;
			if (bus_off)
				control[can_mode_pkg::CTL_INIT] <= 1'b1;
			if (wr_timing)
				bit_timing <= write_data;
			if (wr_prescale)
				prescale_ext <= write_data;
			if (wr_mode)
				schedule_mode <= write_data[1:0];
			if (wr_select)
				select <= write_data[can_mode_pkg::IDX_W-1:0];
		end
	end

	// transmit scheduler: one object in flight at a time
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			busy <= 1'b0;
			busy_idx <= '0;
			tx_req <= 1'b0;
			tx_frame <= '0;
		end else if (!running) begin
			busy <= 1'b0;
			tx_req <= 1'b0;
		end else if (!busy) begin
			if (tx_pick[can_mode_pkg::IDX_W]) begin
				busy <= 1'b1;
				busy_idx <= tx_idx;
				tx_req <= 1'b1;
				tx_frame <= {objects[tx_idx].id, 1'b0, objects[tx_idx].dlc, objects[tx_idx].data};
			end
		end else if (tx_done_ok || tx_failed) begin
			busy <= 1'b0;
			tx_req <= 1'b0;
		end else if (tx_start_ack) begin
			tx_req <= 1'b0;
		end else if (tx_req && (!objects[busy_idx].valid || !objects[busy_idx].pend
			|| obj_wr && select == busy_idx)) begin // withdraw only before the engine starts
			busy <= 1'b0;
			tx_req <= 1'b0;
		end
	end

	// link side outputs and idle counter
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			link_state <= can_mode_pkg::LINK_INIT;
			idle_count <= can_mode_pkg::COUNT_ZERO;
			transfer_enable <= 1'b0;
			tx_pin <= 1'b1;
		end else begin
			link_state <= next_link_state;
			idle_count <= next_idle_count;
			transfer_enable <= next_link_state == can_mode_pkg::LINK_ACTIVE;
			tx_pin <= (next_link_state == can_mode_pkg::LINK_ACTIVE) ? engine_tx_bit : 1'b1;
		end
	end

	// read data, valid in the cycle after the read strobe
	logic [can_mode_pkg::REG_W-1:0] rd_mux;
	always_comb begin
		case (address)
			can_mode_pkg::REG_CONTROL: rd_mux = control;
			can_mode_pkg::REG_STATUS: rd_mux = {12'h000, busy, link_state == can_mode_pkg::LINK_ACTIVE,
				retransmit_disable, init_hold};
			can_mode_pkg::REG_BIT_TIMING: rd_mux = bit_timing;
			can_mode_pkg::REG_PRESCALE_EXT: rd_mux = prescale_ext;
			can_mode_pkg::REG_SCHEDULE_MODE: rd_mux = {14'h0000, schedule_mode};
			can_mode_pkg::REG_OBJ_SELECT: rd_mux = {11'h000, select};
			can_mode_pkg::REG_OBJ_CTRL: rd_mux = {sel_obj.valid, sel_obj.fresh, sel_obj.pend, sel_obj.remote_en,
				sel_obj.dir_tx, sel_obj.use_mask, 6'h00, sel_obj.dlc};
			can_mode_pkg::REG_OBJ_ID_LO: rd_mux = sel_obj.id[15:0];
			can_mode_pkg::REG_OBJ_ID_HI: rd_mux = {3'h0, sel_obj.id[can_mode_pkg::ID_W-1:16]};
			can_mode_pkg::REG_OBJ_MASK_LO: rd_mux = sel_obj.mask[15:0];
			can_mode_pkg::REG_OBJ_MASK_HI: rd_mux = {3'h0, sel_obj.mask[can_mode_pkg::ID_W-1:16]};
			default: rd_mux = data_addr ? sel_obj.data[data_word[1:0]*16 +: 16] : 16'h0000;
		endcase
	end
	always_ff @(posedge clock) begin
		if (!reset_n)
			read_data <= '0;
		else
			read_data <= read_strobe ? rd_mux : 16'h0000;
	end

	// objects below the one in flight, for the priority check
	logic [can_mode_pkg::OBJECTS-1:0] lower_mask;
	assign lower_mask = ~({can_mode_pkg::OBJECTS{1'b1}} << busy_idx);

	// checks
	a_init_tx_recessive: assert property (@(posedge clock) disable iff (!reset_n)
		$past(init_hold) |-> tx_pin && !tx_req) else $error("tx not recessive in init");
	a_timing_locked: assert property (@(posedge clock) disable iff (!reset_n)
		!cfg_open |=> $stable(bit_timing) && $stable(prescale_ext) && $stable(schedule_mode))
		else $error("timing changed while locked");
	a_bus_off_init: assert property (@(posedge clock) disable iff (!reset_n)
		bus_off |=> init_hold) else $error("bus-off did not set init");
	a_idle_before_run: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(transfer_enable) |-> $past(idle_count) == can_mode_pkg::IDLE_COUNT - can_mode_pkg::COUNT_ONE)
		else $error("joined bus before idle");
	a_dominant_restart: assert property (@(posedge clock) disable iff (!reset_n)
		link_state == can_mode_pkg::LINK_WAIT_IDLE && bit_tick && !bus_bit && !init_hold |=> idle_count == 4'h0)
		else $error("idle count not restarted");
	a_dar_clear_pend: assert property (@(posedge clock) disable iff (!reset_n)
		busy && tx_start_ack && retransmit_disable && !obj_wr |=> !objects[$past(busy_idx)].pend)
		else $error("send-pending kept on start");
	a_success_clear_fresh: assert property (@(posedge clock) disable iff (!reset_n)
		busy && tx_done_ok && !obj_wr |=> !objects[$past(busy_idx)].fresh) else $error("fresh kept on success");
	a_one_in_flight: assert property (@(posedge clock) disable iff (!reset_n)
		tx_req |-> busy) else $error("request without object");
	a_tx_follows_engine: assert property (@(posedge clock) disable iff (!reset_n)
		transfer_enable |-> tx_pin == $past(engine_tx_bit))
		else $error("tx pin not driven by engine");
	a_no_send_idle: assert property (@(posedge clock) disable iff (!reset_n)
		!transfer_enable |=> !tx_req)
		else $error("request before bus joined");
	a_config_write_lands: assert property (@(posedge clock) disable iff (!reset_n)
		wr_timing |=> bit_timing == $past(write_data))
		else $error("open timing write lost");
	a_init_keeps_config: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(init_hold) |-> $stable(bit_timing) && $stable(prescale_ext) && $stable(schedule_mode))
		else $error("configuration changed on init");
	a_lowest_first: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(busy) |-> ($past(pend_vec) & lower_mask) == '0)
		else $error("lower pending object skipped");
	a_update_discards: assert property (@(posedge clock) disable iff (!reset_n)
		running && tx_req && !(tx_start_ack || tx_done_ok || tx_failed)
		&& obj_wr && select == busy_idx |=> !busy && !tx_req)
		else $error("old request kept after update");
	a_fail_keeps_pend: assert property (@(posedge clock) disable iff (!reset_n)
		busy && tx_failed && !tx_done_ok && !retransmit_disable && objects[busy_idx].pend && !obj_wr
		|=> objects[$past(busy_idx)].pend) else $error("send-pending lost on failure");
	a_fail_keeps_fresh: assert property (@(posedge clock) disable iff (!reset_n)
		busy && tx_failed && !tx_done_ok && objects[busy_idx].fresh && !obj_wr
		|=> objects[$past(busy_idx)].fresh) else $error("fresh-content lost on failure");
	a_remote_sets_pend: assert property (@(posedge clock) disable iff (!reset_n)
		rx_take && rx_frame.remote && objects[rx_idx].remote_en && !obj_wr && !(busy && busy_idx == rx_idx)
		|=> objects[$past(rx_idx)].pend) else $error("remote frame did not request send");
	a_rx_stores_frame: assert property (@(posedge clock) disable iff (!reset_n)
		rx_take && !rx_frame.remote && !obj_wr && !(busy && busy_idx == rx_idx)
		|=> objects[$past(rx_idx)].data == $past(rx_frame.data) && objects[$past(rx_idx)].fresh)
		else $error("received frame not stored");
endmodule // can_mode_ctrl
`default_nettype wire

// *** rtl/can_mode_pkg.sv ***
// Purpose: shared constants and types of the operating-mode control block
// Assumes: 16-bit register port, one clock at 250 MHz
// Notes: offsets are byte addresses of 16-bit words on the plain register port
package can_mode_pkg;
	localparam int OBJECTS = 32;
	localparam int IDX_W = 5;
	localparam int ID_W = 29;
	localparam int DLC_W = 4;
	localparam int DATA_W = 64;
	localparam int ADDR_W = 8;
	localparam int REG_W = 16;
	localparam int IDLE_BITS = 11;
	localparam logic [3:0] IDLE_COUNT = 4'hB;
	localparam logic [3:0] COUNT_ONE = 4'h1;
	localparam logic [3:0] COUNT_ZERO = 4'h0;
	// bit timing: one bit per BIT_CYCLES clocks, 1 Mbit/s ceiling
	localparam int CLOCK_MHZ = 250;
	localparam int BITRATE_KBPS_MAX = 1000;
	localparam int MIN_BIT_CYCLES = (CLOCK_MHZ * 1000) / BITRATE_KBPS_MAX;
	localparam logic [15:0] MIN_BIT_CYCLES_W = 16'(MIN_BIT_CYCLES);
	// register offsets
	localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h02;
	localparam logic [ADDR_W-1:0] REG_BIT_TIMING = 8'h06;
	localparam logic [ADDR_W-1:0] REG_PRESCALE_EXT = 8'h18;
	localparam logic [ADDR_W-1:0] REG_SCHEDULE_MODE = 8'h28;
	localparam logic [ADDR_W-1:0] REG_OBJ_SELECT = 8'h40;
	localparam logic [ADDR_W-1:0] REG_OBJ_CTRL = 8'h42;
	localparam logic [ADDR_W-1:0] REG_OBJ_ID_LO = 8'h44;
	localparam logic [ADDR_W-1:0] REG_OBJ_ID_HI = 8'h46;
	localparam logic [ADDR_W-1:0] REG_OBJ_MASK_LO = 8'h48;
	localparam logic [ADDR_W-1:0] REG_OBJ_MASK_HI = 8'h4A;
	localparam logic [ADDR_W-1:0] REG_OBJ_DATA0 = 8'h4C;
	localparam logic [ADDR_W-1:0] DATA_SPAN = 8'h08;
	// control field positions
	localparam int CTL_INIT = 0;
	localparam int CTL_CCE = 6;
	localparam int CTL_DAR = 5;
	localparam logic [REG_W-1:0] CONTROL_RESET = 16'h0001;
	localparam logic [REG_W-1:0] BIT_TIMING_RESET = 16'h00F9;
	// object control field positions
	localparam int OC_VALID = 15;
	localparam int OC_FRESH = 14;
	localparam int OC_PEND = 13;
	localparam int OC_REMOTE_EN = 12;
	localparam int OC_DIR_TX = 11;
	localparam int OC_USE_MASK = 10;
	localparam logic [1:0] MODE_CONFIG = 2'h1;
	typedef enum logic [1:0] {
		LINK_INIT = 2'h0,
		LINK_WAIT_IDLE = 2'h1,
		LINK_ACTIVE = 2'h2
	} link_state_t;
	// frame seen by the bitstream engine
	typedef struct packed {
		logic [ID_W-1:0] id;
		logic remote;
		logic [DLC_W-1:0] dlc;
		logic [DATA_W-1:0] data;
	} frame_t;
	// one message object
	typedef struct packed {
		logic valid;
		logic fresh;
		logic pend;
		logic remote_en;
		logic dir_tx;
		logic use_mask;
		logic [ID_W-1:0] id;
		logic [ID_W-1:0] mask;
		logic [DLC_W-1:0] dlc;
		logic [DATA_W-1:0] data;
	} object_t;
endpackage

// *** tb/can_far_end.sv ***
// Purpose: far-side engine model, bit samples and transmit handshake
// Assumes: one bit sample every fourth clock
// Notes: bench sets idle bus level, outcome and start delay
`timescale 1ns/1ps
`default_nettype none
module can_far_end (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic tx_req,
	input wire can_mode_pkg::frame_t tx_frame,
	input wire logic bus_level,
	input wire logic fail_next,
	input wire logic [7:0] ack_delay,
	output logic bit_tick,
	output logic bus_bit,
	output logic tx_start_ack,
	output logic tx_done_ok,
	output logic tx_failed,
	output logic engine_tx_bit,
	output logic [7:0] sent_cnt,
	output can_mode_pkg::frame_t last_frame
);
	logic [1:0] div;
	logic [1:0] phase;
	logic [7:0] wait_cnt;
	// own frame toggles the bus, otherwise the bench's idle level shows
	assign engine_tx_bit = (phase == 2'h2) ? div[0] : 1'b1;
	assign bus_bit = (phase == 2'h2) ? engine_tx_bit : bus_level;
	// start after a delay, drop a withdrawn request, end nine cycles later
	always_ff @(posedge clock) begin
		tx_start_ack <= 1'b0;
		tx_done_ok <= 1'b0;
		tx_failed <= 1'b0;
		div <= div + 2'h1;
		bit_tick <= (div == 2'h3);
		if (!reset_n) begin
			div <= 2'h0;
			phase <= 2'h0;
			sent_cnt <= 8'h00;
			last_frame <= '0;
		end else if (phase == 2'h0 && tx_req) begin
			phase <= 2'h1;
			wait_cnt <= ack_delay;
		end else if (phase == 2'h1 && !tx_req) begin
			phase <= 2'h0;
		end else if (phase == 2'h1 && wait_cnt != 8'h00) begin
			wait_cnt <= wait_cnt - 8'h01;
		end else if (phase == 2'h1) begin
			tx_start_ack <= 1'b1;
			last_frame <= tx_frame;
			phase <= 2'h2;
			wait_cnt <= 8'h08;
		end else if (phase == 2'h2 && wait_cnt != 8'h00) begin
			wait_cnt <= wait_cnt - 8'h01;
		end else if (phase == 2'h2) begin
			tx_failed <= fail_next;
			tx_done_ok <= !fail_next;
			sent_cnt <= sent_cnt + 8'h01;
			phase <= 2'h0;
		end
	end
endmodule // can_far_end
`default_nettype wire

// *** tb/can_init_and_retransmit_control_tb_top.sv ***
// Purpose: self-checking bench of the operating-mode control block
// Assumes: far-side model sends every requested frame not withdrawn before its start
// Notes: cumulative send count orders the scenarios
`timescale 1ns/1ps
`default_nettype none
module can_init_and_retransmit_control_tb_top;
	logic clock, reset_n, write_strobe, read_strobe, bus_off, rx_valid, bus_level, fail_next;
	logic bit_tick, bus_bit, tx_start_ack, tx_done_ok, tx_failed, engine_tx_bit, tx_req, transfer_enable, tx_pin;
	logic [7:0] address, ack_delay, sent_cnt;
	logic [15:0] write_data, read_data, rv;
	can_mode_pkg::frame_t rx_frame, tx_frame, last_frame;
	int error_cnt, check_count;
	int cycles = 0;
	can_mode_ctrl can_mode_ctrl_i (.clock(clock), .reset_n(reset_n), .address(address), .write_data(write_data),
		.write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data), .bus_off(bus_off),
		.bit_tick(bit_tick), .bus_bit(bus_bit), .rx_valid(rx_valid), .rx_frame(rx_frame),
		.tx_start_ack(tx_start_ack), .tx_done_ok(tx_done_ok), .tx_failed(tx_failed),
		.engine_tx_bit(engine_tx_bit), .tx_req(tx_req), .tx_frame(tx_frame),
		.transfer_enable(transfer_enable), .tx_pin(tx_pin));
	can_far_end can_far_end_i (.clock(clock), .reset_n(reset_n), .tx_req(tx_req), .tx_frame(tx_frame),
		.bus_level(bus_level), .fail_next(fail_next), .ack_delay(ack_delay), .bit_tick(bit_tick),
		.bus_bit(bus_bit), .tx_start_ack(tx_start_ack), .tx_done_ok(tx_done_ok), .tx_failed(tx_failed),
		.engine_tx_bit(engine_tx_bit), .sent_cnt(sent_cnt), .last_frame(last_frame));
	// clock and hang guard
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// register port cycles
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1 d = read_data;
	endtask
	task automatic obj(input logic [4:0] n, input logic [28:0] id, input logic [28:0] m, input logic [15:0] c);
		wr(can_mode_pkg::REG_OBJ_SELECT, {11'h000, n});
		wr(can_mode_pkg::REG_OBJ_CTRL, 16'h0000);
		wr(can_mode_pkg::REG_OBJ_ID_LO, id[15:0]);
		wr(can_mode_pkg::REG_OBJ_ID_HI, {3'h0, id[28:16]});
		wr(can_mode_pkg::REG_OBJ_MASK_LO, m[15:0]);
		wr(can_mode_pkg::REG_OBJ_MASK_HI, {3'h0, m[28:16]});
		wr(can_mode_pkg::REG_OBJ_CTRL, c);
	endtask
	task automatic ticks(input int n, input logic lvl);
		bus_level <= lvl;
		repeat (n) begin
			do @(posedge clock); while (bit_tick !== 1'b1);
		end
		repeat (2) @(posedge clock);
	endtask
	task automatic wait_sent(input logic [7:0] n);
		for (int i = 0; i < 600 && sent_cnt !== n; i++) @(posedge clock);
		chk({24'h0, sent_cnt}, {24'h0, n});
	endtask
	task automatic pulse_rx(input can_mode_pkg::frame_t f);
		@(posedge clock);
		rx_frame <= f;
		rx_valid <= 1'b1;
		@(posedge clock);
		rx_valid <= 1'b0;
	endtask
	// scenarios
	task automatic t_reset();
		rd(can_mode_pkg::REG_CONTROL, rv);
		chk({16'h0, rv}, 32'h00000001);
		rd(can_mode_pkg::REG_BIT_TIMING, rv);
		chk({16'h0, rv}, 32'h000000F9);
		rd(8'hFE, rv);
		chk({16'h0, rv}, 32'h00000000);
		chk({31'h0, tx_pin}, 32'h00000001);
	endtask
	task automatic t_config();
		logic [7:0] a[3] = '{can_mode_pkg::REG_BIT_TIMING, can_mode_pkg::REG_PRESCALE_EXT,
			can_mode_pkg::REG_SCHEDULE_MODE};
		for (int i = 0; i < 3; i++) begin
			wr(a[i], 16'h0001);
			rd(a[i], rv);
			chk({16'h0, rv}, (i == 0) ? 32'h000000F9 : 32'h00000000);
		end
		wr(can_mode_pkg::REG_CONTROL, 16'h0041);
		for (int i = 0; i < 3; i++) begin
			wr(a[i], 16'h0001);
			rd(a[i], rv);
			chk({16'h0, rv}, 32'h00000001);
		end
		wr(can_mode_pkg::REG_SCHEDULE_MODE, 16'h0000);
		obj(5'h03, 29'h00000033, 29'h0, 16'hE808);
		obj(5'h01, 29'h00000011, 29'h0, 16'hE808);
		chk({31'h0, tx_req}, 32'h00000000);
		wr(can_mode_pkg::REG_CONTROL, 16'h0040);
		for (int i = 0; i < 3; i++) begin
			wr(a[i], 16'h0002);
			rd(a[i], rv);
			chk({16'h0, rv}, (i == 2) ? 32'h00000000 : 32'h00000001);
		end
	endtask
	task automatic t_join();
		ticks(1, 1'b0);
		ticks(10, 1'b1);
		chk({31'h0, transfer_enable}, 32'h00000000);
		ticks(1, 1'b0);
		ticks(10, 1'b1);
		chk({31'h0, transfer_enable}, 32'h00000000);
		ticks(1, 1'b1);
		chk({31'h0, transfer_enable}, 32'h00000001);
	endtask
	task automatic t_send();
		wait_sent(8'h01);
		chk({3'h0, last_frame.id}, 32'h00000011);
		wait_sent(8'h02);
		chk({3'h0, last_frame.id}, 32'h00000033);
		rd(can_mode_pkg::REG_OBJ_CTRL, rv);
		chk({16'h0, rv}, 32'h00008808);
		fail_next <= 1'b1;
		obj(5'h05, 29'h00000055, 29'h0, 16'hE808);
		wait_sent(8'h03);
		fail_next <= 1'b0;
		wait_sent(8'h04);
		rd(can_mode_pkg::REG_OBJ_CTRL, rv);
		chk({16'h0, rv}, 32'h00008808);
		wr(can_mode_pkg::REG_CONTROL, 16'h0060);
		fail_next <= 1'b1;
		obj(5'h06, 29'h00000066, 29'h0, 16'hE808);
		wait_sent(8'h05);
		fail_next <= 1'b0;
		repeat (60) @(posedge clock);
		chk({24'h0, sent_cnt}, 32'h00000005);
		rd(can_mode_pkg::REG_OBJ_CTRL, rv);
		chk({16'h0, rv}, 32'h0000C808);
		wr(can_mode_pkg::REG_OBJ_CTRL, 16'hE808);
		wait_sent(8'h06);
		rd(can_mode_pkg::REG_OBJ_CTRL, rv);
		chk({16'h0, rv}, 32'h00008808);
	endtask
	task automatic t_update();
		ack_delay <= 8'h28;
		obj(5'h07, 29'h00000077, 29'h0, 16'hE808);
		for (int i = 0; i < 200 && tx_req !== 1'b1; i++) @(posedge clock);
		wr(can_mode_pkg::REG_OBJ_DATA0, 16'h2222);
		wait_sent(8'h07);
		chk({16'h0, last_frame.data[15:0]}, 32'h00002222);
		ack_delay <= 8'h02;
	endtask
	task automatic t_rx();
		logic [63:0] d = 64'h0123456789ABCDEF;
		obj(5'h08, 29'h00000120, 29'h1FFFFFF0, 16'h8408);
		pulse_rx({29'h00000125, 1'b0, 4'h8, d});
		rd(can_mode_pkg::REG_OBJ_ID_LO, rv);
		chk({16'h0, rv}, 32'h00000125);
		rd(can_mode_pkg::REG_OBJ_CTRL, rv);
		chk({16'h0, rv}, 32'h0000C408);
		for (int i = 0; i < 4; i++) begin
			rd(can_mode_pkg::REG_OBJ_DATA0 + 8'(2 * i), rv);
			chk({16'h0, rv}, {16'h0, d[16*i +: 16]});
		end
		obj(5'h09, 29'h00000ABC, 29'h0, 16'h9808);
		pulse_rx({29'h00000ABC, 1'b1, 4'h0, 64'h0});
		wait_sent(8'h08);
		chk({3'h0, last_frame.id}, 32'h00000ABC);
	endtask
	task automatic t_bus_off();
		@(posedge clock);
		bus_off <= 1'b1;
		@(posedge clock);
		bus_off <= 1'b0;
		rd(can_mode_pkg::REG_CONTROL, rv);
		chk({16'h0, rv}, 32'h00000061);
		rd(can_mode_pkg::REG_BIT_TIMING, rv);
		chk({16'h0, rv}, 32'h00000001);
		chk({30'h0, tx_pin, transfer_enable}, 32'h00000002);
	endtask
	// main sequence
	initial begin
		{reset_n, write_strobe, read_strobe, bus_off, rx_valid, fail_next} = 6'h00;
		bus_level = 1'b1;
		address = 8'h00;
		write_data = 16'h0000;
		rx_frame = '0;
		ack_delay = 8'h02;
		error_cnt = 0;
		check_count = 0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		t_reset();
		t_config();
		t_join();
		t_send();
		t_update();
		t_rx();
		t_bus_off();
		give_verdict();
	end
endmodule // can_init_and_retransmit_control_tb_top
`default_nettype wire
